// File: shared/lal_params.svh
`ifndef LAL_PARAMS_SVH
`define LAL_PARAMS_SVH
// Register pointers
`define LAL_ADDR_SRC_CFG 8'h06
`define LAL_ADDR_THRESH 8'h07
// Alert source configuration fields
`define LAL_BIT_SHUNT_OVER 15
`define LAL_BIT_SHUNT_UNDER 14
`define LAL_BIT_BUS_OVER 13
`define LAL_BIT_BUS_UNDER 12
`define LAL_BIT_POWER_OVER 11
`define LAL_BIT_READY 10
`define LAL_BIT_LIMIT_HIT 4
`define LAL_BIT_CONV_DONE 3
`define LAL_BIT_OVERFLOW 2
`define LAL_BIT_POLARITY 1
`define LAL_BIT_LATCH 0
// Writable bits of the source configuration
`define LAL_SRC_CFG_WMASK 16'hfc03
// Reset values
`define LAL_SRC_CFG_RST 16'h0000
`define LAL_THRESH_RST 16'h0000
`endif

// File: shared/lal_pkg.sv
package lal_pkg;
	// Result kind presented with a conversion strobe
	typedef enum logic [1:0] {
		LAL_RES_SHUNT = 2'h0,
		LAL_RES_BUS = 2'h1,
		LAL_RES_POWER = 2'h3
	} lal_result_e;
	// Limit function chosen by priority
	typedef enum logic [2:0] {
		LAL_FN_NONE = 3'h0,
		LAL_FN_SHUNT_OVER = 3'h1,
		LAL_FN_SHUNT_UNDER = 3'h3,
		LAL_FN_BUS_OVER = 3'h2,
		LAL_FN_BUS_UNDER = 3'h6,
		LAL_FN_POWER_OVER = 3'h7
	} lal_func_e;
endpackage : lal_pkg

// File: logic/lal_limit_compare.sv
`timescale 1ns/10ps
`include "lal_params.svh"
module lal_limit_compare
	import lal_pkg::*;
#(
	parameter int W = 16
) (
	// Enables and operands
	input wire logic [15:0] src_cfg,
	input wire logic signed [W-1:0] shunt_value,
	input wire logic signed [W-1:0] bus_value,
	input wire logic signed [W-1:0] power_value,
	input wire logic [W-1:0] threshold,
	// Outcome
	output lal_func_e func,
	output logic hit
);
	// Highest enabled function wins
	always_comb begin
		if (src_cfg[`LAL_BIT_SHUNT_OVER]) begin
			func = LAL_FN_SHUNT_OVER;
		end else if (src_cfg[`LAL_BIT_SHUNT_UNDER]) begin
			func = LAL_FN_SHUNT_UNDER;
		end else if (src_cfg[`LAL_BIT_BUS_OVER]) begin
			func = LAL_FN_BUS_OVER;
		end else if (src_cfg[`LAL_BIT_BUS_UNDER]) begin
			func = LAL_FN_BUS_UNDER;
		end else if (src_cfg[`LAL_BIT_POWER_OVER]) begin
			func = LAL_FN_POWER_OVER;
		end else begin
			func = LAL_FN_NONE;
		end
	end

	// Shunt is signed; bus and power are unsigned codes
	always_comb begin
		unique case (func)
			LAL_FN_SHUNT_OVER: hit = shunt_value > $signed(threshold);
			LAL_FN_SHUNT_UNDER: hit = shunt_value < $signed(threshold);
			LAL_FN_BUS_OVER: hit = $unsigned(bus_value) > threshold;
			LAL_FN_BUS_UNDER: hit = $unsigned(bus_value) < threshold;
			LAL_FN_POWER_OVER: hit = $unsigned(power_value) > threshold;
			default: hit = 1'b0;
		endcase
	end
endmodule : lal_limit_compare

// File: logic/lal_limit_alert.sv
// Functional notes
// - Bus-over enable bit 13: alert when bus result exceeds threshold.
// - Bus-under enable bit 12: alert when bus result is below threshold.
// - Power-over enable bit 11: alert when power result exceeds threshold.
// - Ready-alert enable bit 10: alert whenever conversion-done flag sets.
// - One limit function drives alert; limit-hit flag bit 4 records it.
// - Latch mode: limit-hit flag clears only on source config read.
// - Transparent mode: limit-hit clears after next non-alerting conversion.
// - Conversion-done flag bit 3 sets after conversion, averaging, multiply finish.
// - Single-shot: done clears on active config write or source config read.
// - Math-overflow flag bit 2 sets on arithmetic overflow.
// - Polarity bit 1: 0 active-low default, 1 active-high.
// - Latch bit 0: 0 transparent default, 1 latched, alert and flags.
// - Transparent mode: alert and flags idle once fault disappears.
// - Latch mode: alert and flags hold until source config read.
// - Selected result compared against 16-bit threshold at 07h.
// - Several limit enables: highest bit among 15..11 wins.
// - Shunt-over enable bit 15: alert when shunt result exceeds threshold.
// - Shunt-under enable bit 14: alert when shunt result is below threshold.
`timescale 1ns/10ps
`include "lal_params.svh"
module lal_limit_alert
	import lal_pkg::*;
#(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register access from serial front end
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Configuration register events
	input wire logic cfg_wr,
	input wire logic cfg_wr_active,
	input wire logic single_shot,
	// Conversion results
	input wire logic result_valid,
	input wire logic signed [W-1:0] shunt_value,
	input wire logic signed [W-1:0] bus_value,
	input wire logic signed [W-1:0] power_value,
	input wire logic cycle_done,
	input wire logic math_overflow,
	// Open-collector alert pin
	input wire logic alert_in,
	output logic alert_out,
	output logic alert_oe
);
	logic [15:0] enables_q;
	logic polarity_q;
	logic latch_q;
	logic [W-1:0] threshold_q;
	logic limit_hit_q;
	logic conv_done_q;
	logic overflow_q;
	logic alert_act_q;
	logic limit_live_q;
	logic limit_live_d;
	logic hit;
	lal_func_e func;
	logic src_rd;
	logic src_wr;
	logic [15:0] src_cfg;

	assign src_rd = reg_rd && (reg_addr == `LAL_ADDR_SRC_CFG);
	assign src_wr = reg_wr && (reg_addr == `LAL_ADDR_SRC_CFG);
	assign src_cfg = enables_q;

	//////////////////////////////////////////////////////////////////////////////
	// Comparator
	lal_limit_compare #(
		.W(W)
	) u_cmp (
		.src_cfg(src_cfg),
		.shunt_value(shunt_value),
		.bus_value(bus_value),
		.power_value(power_value),
		.threshold(threshold_q),
		.func(func),
		.hit(hit)
	);

	//////////////////////////////////////////////////////////////////////////////
	// Software-written configuration
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			enables_q <= `LAL_SRC_CFG_RST;
		end else if (src_wr) begin
			enables_q <= reg_wdata & `LAL_SRC_CFG_WMASK;
		end
	end

	// Polarity and latch bits read out of the enable word
	assign polarity_q = enables_q[`LAL_BIT_POLARITY];
	assign latch_q = enables_q[`LAL_BIT_LATCH];

	// Threshold register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			threshold_q <= W'(`LAL_THRESH_RST);
		end else if (reg_wr && (reg_addr == `LAL_ADDR_THRESH)) begin
			threshold_q <= reg_wdata[W-1:0];
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Live limit state; a completed result replaces the held outcome
	always_comb begin
		if (func == LAL_FN_NONE) begin
			limit_live_d = 1'b0;
		end else if (result_valid) begin
			limit_live_d = hit;
		end else begin
			limit_live_d = limit_live_q;
		end
	end

	// Held between results so the transparent alert has a level to follow
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			limit_live_q <= 1'b0;
		end else begin
			limit_live_q <= limit_live_d;
		end
	end

	// Limit-hit flag; a new hit beats a clearing read
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			limit_hit_q <= 1'b0;
		end else if (result_valid && hit && func != LAL_FN_NONE) begin
			limit_hit_q <= 1'b1;
		end else if (latch_q) begin
			if (src_rd) begin
				limit_hit_q <= 1'b0;
			end
		end else if (result_valid) begin
			limit_hit_q <= 1'b0;
		end
	end

	// Conversion-done flag; set wins over clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_done_q <= 1'b0;
		end else if (cycle_done) begin
			conv_done_q <= 1'b1;
		end else if (src_rd || (single_shot && cfg_wr && cfg_wr_active)) begin
			conv_done_q <= 1'b0;
		end
	end

	// Overflow flag; transparent follows the math, latched holds to a read
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			overflow_q <= 1'b0;
		end else if (math_overflow) begin
			overflow_q <= 1'b1;
		end else if (latch_q ? src_rd : cycle_done) begin
			overflow_q <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Alert activity; ready alert tracks the done flag
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			alert_act_q <= 1'b0;
		end else if ((result_valid && hit && func != LAL_FN_NONE) ||
			(cycle_done && enables_q[`LAL_BIT_READY])) begin
			alert_act_q <= 1'b1;
		end else if (latch_q) begin
			if (src_rd) begin
				alert_act_q <= 1'b0;
			end
		end else begin
			// Transparent: a clean result drops the alert at once, not an edge later
			alert_act_q <= limit_live_d ||
				(conv_done_q && enables_q[`LAL_BIT_READY]);
		end
	end

	// Open collector: drive low when the pin level must be low
	assign alert_out = 1'b0;
	assign alert_oe = polarity_q ? !alert_act_q : alert_act_q;

	//////////////////////////////////////////////////////////////////////////////
	// Read data, registered
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`LAL_ADDR_SRC_CFG: begin
					reg_rdata <= enables_q;
					reg_rdata[`LAL_BIT_LIMIT_HIT] <= limit_hit_q;
					reg_rdata[`LAL_BIT_CONV_DONE] <= conv_done_q;
					reg_rdata[`LAL_BIT_OVERFLOW] <= overflow_q;
				end
				`LAL_ADDR_THRESH: reg_rdata <= 16'(threshold_q);
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end

	// Pin level readback unused by this block
	logic unused_alert_in;
	assign unused_alert_in = alert_in;
endmodule : lal_limit_alert

// File: verification/lal_limit_alert_properties.sv
`timescale 1ns/10ps
`include "lal_params.svh"
module lal_limit_alert_properties #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register side
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// Results and pin
	input wire logic result_valid,
	input wire logic signed [W-1:0] shunt_value,
	input wire logic signed [W-1:0] bus_value,
	input wire logic signed [W-1:0] power_value,
	input wire logic cycle_done,
	input wire logic alert_oe
);
	logic [15:0] cfg_q;
	logic [15:0] thr_q;
	logic act;
	// Shadow copies, so the properties know enables and limit
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n) {cfg_q, thr_q} <= 32'h0000_0000;
		else if (reg_wr && reg_addr == `LAL_ADDR_SRC_CFG) cfg_q <= reg_wdata & `LAL_SRC_CFG_WMASK;
		else if (reg_wr && reg_addr == `LAL_ADDR_THRESH) thr_q <= reg_wdata;
	// Alert active, whatever the pin polarity
	assign act = alert_oe ^ cfg_q[1];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////////
	sequence s_res(en);
		result_valid && !reg_wr && cfg_q[15:10] == en && !cfg_q[0];
	endsequence
	sequence s_rd_src;
		reg_rd && reg_addr == `LAL_ADDR_SRC_CFG && !reg_wr && !result_valid;
	endsequence
	a_bus_over: assert property (s_res(6'h08) |=> act == ($past(bus_value) > $past(thr_q)))
		else $error("bus over compare wrong");
	a_bus_under: assert property (s_res(6'h04) |=> act == ($past(bus_value) < $past(thr_q)))
		else $error("bus under compare wrong");
	a_power_over: assert property (s_res(6'h02) |=> act == ($past(power_value) > $past(thr_q)))
		else $error("power over compare wrong");
	a_shunt_over: assert property (s_res(6'h20) |=> act == ($past(shunt_value) > $signed($past(thr_q))))
		else $error("shunt over compare wrong");
	a_over_first: assert property (s_res(6'h0c) |=> act == ($past(bus_value) > $past(thr_q)))
		else $error("priority wrong");
	a_latch_hold: assert property (cfg_q[0] && act && !reg_wr && !reg_rd |=> act)
		else $error("latched alert dropped");
	a_read_clear: assert property (s_rd_src ##0 cfg_q[0] && !cfg_q[10] |=> !act)
		else $error("read did not clear alert");
	a_ready_alert: assert property (cycle_done && cfg_q[10] && !reg_wr && !reg_rd |=> act)
		else $error("ready alert missing");
	a_thr_read: assert property (reg_rd && reg_addr == `LAL_ADDR_THRESH && !reg_wr |=> reg_rdata == thr_q)
		else $error("threshold read wrong");
endmodule : lal_limit_alert_properties
bind lal_limit_alert lal_limit_alert_properties #(.W(W)) lal_limit_alert_properties_inst (.ref_clk,
	.rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .result_valid, .shunt_value,
	.bus_value, .power_value, .cycle_done, .alert_oe);

// File: verification/lal_host_model.sv
`timescale 1ns/10ps
module lal_host_model (
	// Device pin drive
	input wire logic alert_out,
	input wire logic alert_oe,
	// Line as the host sees it
	output logic alert_pin
);
	// Pull-up holds the line high unless the device sinks it
	assign alert_pin = alert_oe ? alert_out : 1'b1;
endmodule : lal_host_model

// File: verification/testbench.sv
`timescale 1ns/10ps
`include "lal_params.svh"
`define CMP(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
	$display("ERROR %0t got %h exp %h", $time, a, e); end end
module testbench;
	logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cfg_wr = 1'b0;
	logic cfg_wr_active = 1'b0, single_shot = 1'b0, result_valid = 1'b0, cycle_done = 1'b0;
	logic math_overflow = 1'b0, chk = 1'b0, rd_seen = 1'b0, ev_seen = 1'b0;
	logic alert_out, alert_oe, alert_pin;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, thr, e;
	logic signed [15:0] shunt_value = 16'h0000, bus_value = 16'h0000, power_value = 16'h0000;
	logic [15:0] expq[$];
	int n_fail = 0, n_compared = 0;
	always #20 ref_clk = ~ref_clk;
	lal_limit_alert #(.W(16)) lal_limit_alert_inst (.ref_clk, .rst_n, .reg_addr, .reg_wr,
		.reg_wdata, .reg_rd, .reg_rdata, .cfg_wr, .cfg_wr_active, .single_shot, .result_valid,
		.shunt_value, .bus_value, .power_value, .cycle_done, .math_overflow,
		.alert_in(alert_pin), .alert_out, .alert_oe);
	lal_host_model lal_host_model_inst (.alert_out, .alert_oe, .alert_pin);
	////////////////////////////////////////////////////////////////////////////////
	// Results settle one edge after they are taken, so check on the edge after that
	always @(posedge ref_clk) begin
		if (rd_seen || ev_seen) begin
			e = (expq.size() > 0) ? expq.pop_front() : 16'hdead;
			`CMP(rd_seen ? reg_rdata : {15'h0000, alert_pin}, e)
		end
		rd_seen <= reg_rd;
		ev_seen <= chk;
	end
	// One strobe cycle, then one idle edge so strobes never meet
	task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		{reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
		@(posedge ref_clk);
		{reg_wr, reg_rd} <= 2'b00;
	endtask : acc
	task automatic rd(input logic [7:0] a, input logic [15:0] x);
		expq.push_back(x);
		acc(1'b0, a, 16'h0000);
	endtask : rd
	// Kind bits are overflow, done, result; expected pin level afterwards
	task automatic conv(input logic [2:0] k, input logic [15:0] x, input logic p);
		expq.push_back({15'h0000, p});
		@(posedge ref_clk);
		{math_overflow, cycle_done, result_valid, chk} <= {k, 1'b1};
		{shunt_value, bus_value, power_value} <= {3{x}};
		@(posedge ref_clk);
		{math_overflow, cycle_done, result_valid, chk} <= 4'h0;
	endtask : conv
	task automatic tend(input string s);
		$display("test %0s done", s);
	endtask : tend
	task automatic final_report;
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h46659063));
		thr = 16'h0100 + 16'($urandom_range(24576));
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int a = 5; a < 8; a++) rd(a[7:0], 16'h0000);
		tend("reset");
		acc(1'b1, 8'h07, thr);
		rd(8'h07, thr);
		acc(1'b1, 8'h06, 16'hffff);
		rd(8'h06, 16'hfc03);
		tend("registers");
		// Every limit function, hit then equal value, which never alerts
		for (int i = 0; i < 5; i++) begin
			acc(1'b1, 8'h06, 16'h8000 >> i);
			conv(3'b001, i % 2 ? thr - 16'h0001 : thr + 16'h0001, 1'b0);
			conv(3'b001, thr, 1'b1);
		end
		tend("functions");
		acc(1'b1, 8'h06, 16'h3000);
		conv(3'b001, thr - 16'h0001, 1'b1);
		conv(3'b001, thr + 16'h0001, 1'b0);
		rd(8'h06, 16'h3010);
		conv(3'b001, thr, 1'b1);
		tend("priority");
		acc(1'b1, 8'h06, 16'h2003);
		conv(3'b000, thr, 1'b0);
		conv(3'b001, thr + 16'h0001, 1'b1);
		conv(3'b001, thr, 1'b1);
		rd(8'h06, 16'h2013);
		conv(3'b000, thr, 1'b0);
		tend("latch");
		single_shot <= 1'b1;
		acc(1'b1, 8'h06, 16'h0400);
		conv(3'b010, thr, 1'b0);
		conv(3'b110, thr, 1'b0);
		rd(8'h06, 16'h040c);
		conv(3'b000, thr, 1'b1);
		conv(3'b010, thr, 1'b0);
		@(posedge ref_clk);
		{cfg_wr, cfg_wr_active} <= 2'b10;
		@(posedge ref_clk);
		{cfg_wr, cfg_wr_active} <= 2'b00;
		conv(3'b000, thr, 1'b0);
		@(posedge ref_clk);
		{cfg_wr, cfg_wr_active} <= 2'b11;
		@(posedge ref_clk);
		{cfg_wr, cfg_wr_active} <= 2'b00;
		conv(3'b000, thr, 1'b1);
		rd(8'h06, 16'h0400);
		tend("ready");
		repeat (3) @(posedge ref_clk);
		final_report();
	end
endmodule : testbench
